//--- design/cmss_regs.svh
`ifndef CMSS_REGS_SVH
`define CMSS_REGS_SVH

`define CMSS_FRAME_BITS 40
`define CMSS_CNT_W 6
`define CMSS_CRC_POLY 8'h2f
`define CMSS_CRC_INIT 8'hff
`define CMSS_IDLE_WORD 40'h00_0000_0000
`define CMSS_CLK_NS 5
`define CMSS_IDLE_TIMEOUT_S 60
`define CMSS_LINK_TIMEOUT_S 1
`define CMSS_NS_PER_S 1000000000
`define CMSS_BLINK_MIN_MS 100
`define CMSS_BLINK_MAX_MS 8000
`define CMSS_NS_PER_MS 1000000
`define CMSS_ERRCNT_W 8
`define CMSS_CMD_W 4
`define CMSS_CID_W 4
`define CMSS_ADDR_W 7
`define CMSS_DATA_W 16
`define CMSS_CRC_W 8

`endif

//--- design/cmss_pkg.sv
package cmss_pkg;
   // Frame layout, sent most significant field first: data, addr, ms, cid, cmd, crc
   typedef struct packed {
      logic [15:0] data;
      logic [6:0] addr;
      logic ms;
      logic [3:0] cid;
      logic [3:0] cmd;
      logic [7:0] crc;
   } cmss_frame_t;

   typedef enum logic [2:0] {
      CMSS_NORMAL = 3'b001,
      CMSS_IDLE = 3'b010,
      CMSS_RESET = 3'b100
   } cmss_mode_t;

   // Serial pins driven by the host
   typedef struct packed {
      logic chip_select_bar;
      logic sclk;
      logic si;
   } cmss_spi_in_t;
endpackage : cmss_pkg

//--- design/cmss_crc8.sv
`timescale 1ns/1ps
`include "cmss_regs.svh"
// Serial CRC over a 32-bit payload, MSB first
module cmss_crc8 (
   input wire logic [31:0] payload,
   output logic [7:0] crc
);
   function automatic logic [7:0] cmss_crc_calc(input logic [31:0] p);
      logic [7:0] c;
      logic fb;
      c = `CMSS_CRC_INIT;
      for (int i = 31; i >= 0; i--) begin
         fb = c[7] ^ p[i];
         c = {c[6:0], 1'b0};
         if (fb) begin
            c = c ^ `CMSS_CRC_POLY;
         end
      end
      return c;
   endfunction : cmss_crc_calc

   assign crc = cmss_crc_calc(payload);
endmodule : cmss_crc8

//--- design/cmss_spi_slave.sv
`timescale 1ns/1ps
`include "cmss_regs.svh"
module cmss_spi_slave
   import cmss_pkg::*;
#(
   parameter longint unsigned IDLE_CYCLES =
      `CMSS_IDLE_TIMEOUT_S * (64'(`CMSS_NS_PER_S) / `CMSS_CLK_NS),
   parameter int unsigned LINK_CYCLES =
      `CMSS_LINK_TIMEOUT_S * (`CMSS_NS_PER_S / `CMSS_CLK_NS),
   parameter int unsigned MS_CYCLES = `CMSS_NS_PER_MS / `CMSS_CLK_NS
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire cmss_pkg::cmss_spi_in_t spi_in,
   output logic so,
   output logic so_oe,
   input wire logic [39:0] answer_word,
   output cmss_pkg::cmss_frame_t rx_frame,
   output logic rx_valid,
   input wire logic daisy_chain_transport_act,
   input wire logic initialized,
   input wire logic cyclic_active,
   input wire logic [12:0] blink_period_ms,
   input wire logic cal_enable_set,
   output logic cal_enabled,
   input wire logic cal_load_req,
   output logic cal_load_start,
   input wire logic gpio0_in,
   input wire logic gpio0_is_fault,
   output logic wake_event,
   output logic fault_chain_in,
   input wire logic link_error_clear,
   output logic link_error_flag,
   output logic [7:0] link_error_count,
   output logic normal_mode_indicator,
   output logic self_reset
);
   import cmss_pkg::*;

   localparam int unsigned MS_W = 32;
   // Timeout counters sized from their limits; sixty seconds needs more than 32 bits
   localparam int unsigned IDLE_W = $clog2(IDLE_CYCLES + 1);
   localparam int unsigned LINK_W = $clog2(LINK_CYCLES + 1);

   // Pin edge detection; pins are taken as synchronous to sys_clk
   logic sclk_q, csb_q, gpio0_q;
   wire sclk_rise = spi_in.sclk & ~sclk_q;
   wire sclk_fall = ~spi_in.sclk & sclk_q;
   wire cs_start = ~spi_in.chip_select_bar & csb_q;
   wire cs_end = spi_in.chip_select_bar & ~csb_q;
   wire cs_act = ~spi_in.chip_select_bar;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sclk_q <= 1'b0;
         csb_q <= 1'b1;
         gpio0_q <= 1'b0;
      end else begin
         sclk_q <= spi_in.sclk;
         csb_q <= spi_in.chip_select_bar;
         gpio0_q <= gpio0_in;
      end
   end

   // Receive shifter and bit counter; counter saturates so long frames stay long
   logic [39:0] rx_sr_q, rx_sr_d;
   logic [`CMSS_CNT_W-1:0] bit_cnt_q, bit_cnt_d;
   wire cnt_sat = (bit_cnt_q == {`CMSS_CNT_W{1'b1}});

   assign rx_sr_d = (cs_act && sclk_rise) ? {rx_sr_q[38:0], spi_in.si} : rx_sr_q;
   assign bit_cnt_d = cs_start ? '0
                    : (cs_act && sclk_rise && !cnt_sat) ? bit_cnt_q + 1'b1
                    : bit_cnt_q;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rx_sr_q <= '0;
         bit_cnt_q <= '0;
      end else begin
         rx_sr_q <= rx_sr_d;
         bit_cnt_q <= bit_cnt_d;
      end
   end

   // Frame check at release of chip select
   logic [7:0] crc_calc;
   cmss_crc8 u_crc (
      .payload(rx_sr_q[39:8]),
      .crc(crc_calc)
   );
   wire len_ok = (bit_cnt_q == 6'(`CMSS_FRAME_BITS));
   wire crc_ok = (crc_calc == rx_sr_q[7:0]);
   wire frame_good = cs_end && len_ok && crc_ok;
   wire frame_bad = cs_end && (bit_cnt_q != '0) && !(len_ok && crc_ok);

   // Field split follows the frame struct: data, addr, ms, cid, cmd, crc
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rx_frame <= '0;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= frame_good;
         if (frame_good) begin
            rx_frame <= cmss_frame_t'(rx_sr_q);
         end
      end
   end

   // Transmit shifter; answer_word is the reply prepared from the previous request
   logic [39:0] tx_sr_q, tx_sr_d;
   logic have_req_q;
   wire [39:0] tx_load = have_req_q ? answer_word : `CMSS_IDLE_WORD;

   assign tx_sr_d = cs_start ? tx_load
                  : (cs_act && sclk_fall) ? {tx_sr_q[38:0], 1'b0}
                  : tx_sr_q;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         tx_sr_q <= '0;
         have_req_q <= 1'b0;
      end else begin
         tx_sr_q <= tx_sr_d;
         if (frame_good) begin
            have_req_q <= 1'b1;
         end
      end
   end

   // Output enabled only under select; slave never drives the clock
   assign so = tx_sr_q[39];
   assign so_oe = cs_act;

   // Link error flag: a fault in the clearing cycle still sets it
   logic [7:0] err_cnt_q;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         link_error_flag <= 1'b0;
         err_cnt_q <= '0;
      end else begin
         if (frame_bad) begin
            link_error_flag <= 1'b1;
         end else if (link_error_clear) begin
            link_error_flag <= 1'b0;
         end
         if (frame_bad && err_cnt_q != 8'hff) begin
            err_cnt_q <= err_cnt_q + 8'h01;
         end
      end
   end
   assign link_error_count = err_cnt_q;

   // Operating mode machine
   cmss_mode_t mode_q, mode_d;
   logic [IDLE_W-1:0] idle_cnt_q;
   logic [LINK_W-1:0] link_cnt_q;
   wire bus_act = cs_act || sclk_rise;
   wire wake = !gpio0_is_fault && gpio0_in && !gpio0_q;
   wire idle_hit = (idle_cnt_q == IDLE_W'(IDLE_CYCLES - 1));
   wire link_hit = initialized && (link_cnt_q == LINK_W'(LINK_CYCLES - 1));

   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         CMSS_NORMAL: begin
            if (link_hit) begin
               mode_d = CMSS_RESET;
            end else if (idle_hit) begin
               mode_d = CMSS_IDLE;
            end
         end
         CMSS_IDLE: begin
            if (bus_act || wake) begin
               mode_d = CMSS_NORMAL;
            end
         end
         CMSS_RESET: begin
            mode_d = CMSS_NORMAL;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mode_q <= CMSS_NORMAL;
         idle_cnt_q <= '0;
         link_cnt_q <= '0;
      end else begin
         mode_q <= mode_d;
         idle_cnt_q <= (bus_act || mode_q != CMSS_NORMAL) ? '0 : idle_cnt_q + 1'b1;
         // Transport timer runs only once initialised, so it never starts past its limit
         link_cnt_q <= (daisy_chain_transport_act || !initialized || mode_q != CMSS_NORMAL) ? '0
                     : link_cnt_q + 1'b1;
      end
   end
   assign self_reset = (mode_q == CMSS_RESET);

   // Blink during cyclic acquisition; period clamped into the legal range
   logic [12:0] ms_cnt_q;
   logic [MS_W-1:0] tick_q;
   logic blink_q;
   wire [12:0] per_ms = (blink_period_ms < 13'(`CMSS_BLINK_MIN_MS)) ? 13'(`CMSS_BLINK_MIN_MS)
                      : (blink_period_ms > 13'(`CMSS_BLINK_MAX_MS)) ? 13'(`CMSS_BLINK_MAX_MS)
                      : blink_period_ms;
   wire ms_tick = (tick_q == MS_W'(MS_CYCLES - 1));
   wire half_done = ms_tick && (ms_cnt_q >= (per_ms >> 1) - 13'd1);

   always_ff @(posedge sys_clk) begin
      if (reset || !cyclic_active) begin
         tick_q <= '0;
         ms_cnt_q <= '0;
         blink_q <= 1'b1;
      end else begin
         tick_q <= ms_tick ? '0 : tick_q + 1'b1;
         if (half_done) begin
            ms_cnt_q <= '0;
            blink_q <= ~blink_q;
         end else if (ms_tick) begin
            ms_cnt_q <= ms_cnt_q + 13'd1;
         end
      end
   end
   assign normal_mode_indicator = (mode_q == CMSS_NORMAL) && blink_q;

   // Calibration memory enable cleared by every reset, including self reset
   always_ff @(posedge sys_clk) begin
      if (reset || self_reset) begin
         cal_enabled <= 1'b0;
         cal_load_start <= 1'b0;
      end else begin
         if (cal_enable_set) begin
            cal_enabled <= 1'b1;
         end
         cal_load_start <= cal_enabled && cal_load_req;
      end
   end

   // General pin zero routing
   assign wake_event = wake;
   assign fault_chain_in = gpio0_is_fault & gpio0_in;

   // Checks
   a_good_frame_latch: assert property (@(posedge sys_clk) disable iff (reset)
      frame_good |=> rx_valid && rx_frame == $past(rx_sr_q))
      else $error("good frame not latched");
   a_bad_frame_drop: assert property (@(posedge sys_clk) disable iff (reset)
      (cs_end && !len_ok) |=> !rx_valid)
      else $error("wrong length frame accepted");
   a_err_flag_set: assert property (@(posedge sys_clk) disable iff (reset)
      frame_bad |=> link_error_flag)
      else $error("link error flag not set");
   a_err_count_inc: assert property (@(posedge sys_clk) disable iff (reset)
      (frame_bad && err_cnt_q != 8'hff) |=> err_cnt_q == $past(err_cnt_q) + 8'h01)
      else $error("error counter not bumped");
   a_first_idle_word: assert property (@(posedge sys_clk) disable iff (reset)
      (cs_start && !have_req_q) |=> tx_sr_q == `CMSS_IDLE_WORD)
      else $error("first reply not idle word");
   a_prev_answer: assert property (@(posedge sys_clk) disable iff (reset)
      (cs_start && have_req_q) |=> tx_sr_q == $past(answer_word))
      else $error("reply not previous answer");
   a_msb_shift: assert property (@(posedge sys_clk) disable iff (reset)
      (cs_act && sclk_fall && !cs_start) |=> so == $past(tx_sr_q[38]))
      else $error("not shifting msb first");
   a_idle_timeout: assert property (@(posedge sys_clk) disable iff (reset)
      (mode_q == CMSS_NORMAL && idle_hit && !link_hit) |=> !normal_mode_indicator)
      else $error("idle timeout kept indicator on");
   a_link_reset: assert property (@(posedge sys_clk) disable iff (reset)
      (mode_q == CMSS_NORMAL && link_hit) |=> self_reset ##1 !cal_enabled)
      else $error("transport timeout missed");
   a_reset_normal: assert property (@(posedge sys_clk)
      reset |=> mode_q == CMSS_NORMAL && !cal_enabled)
      else $error("reset not normal mode");

   // Frame acceptance and shifter behaviour
   a_bad_crc_drop: assert property (@(posedge sys_clk) disable iff (reset)
      (cs_end && !crc_ok) |=> !rx_valid)
      else $error("bad check field frame accepted");
   a_valid_pulse: assert property (@(posedge sys_clk) disable iff (reset)
      rx_valid |=> !rx_valid)
      else $error("frame valid longer than one cycle");
   a_bits_cleared: assert property (@(posedge sys_clk) disable iff (reset)
      cs_start |=> bit_cnt_q == '0)
      else $error("bit counter not cleared at select");
   a_tx_hold: assert property (@(posedge sys_clk) disable iff (reset)
      (!cs_start && !(cs_act && sclk_fall)) |=> $stable(tx_sr_q))
      else $error("reply moved without clock fall");

   // Fault record keeps its state between events
   a_flag_sticky: assert property (@(posedge sys_clk) disable iff (reset)
      (link_error_flag && !link_error_clear) |=> link_error_flag)
      else $error("link error flag lost");
   a_flag_clear: assert property (@(posedge sys_clk) disable iff (reset)
      (link_error_clear && !frame_bad) |=> !link_error_flag)
      else $error("link error flag not cleared");
   a_count_hold: assert property (@(posedge sys_clk) disable iff (reset)
      !frame_bad |=> err_cnt_q == $past(err_cnt_q))
      else $error("error counter moved without fault");
   a_count_sat: assert property (@(posedge sys_clk) disable iff (reset)
      (err_cnt_q == 8'hff) |=> err_cnt_q == 8'hff)
      else $error("error counter wrapped");

   // Mode and indicator
   a_ind_steady: assert property (@(posedge sys_clk) disable iff (reset)
      !cyclic_active |=> (mode_q != CMSS_NORMAL || normal_mode_indicator))
      else $error("indicator off in normal mode");
   a_idle_wake: assert property (@(posedge sys_clk) disable iff (reset)
      (mode_q == CMSS_IDLE && (bus_act || wake)) |=> mode_q == CMSS_NORMAL)
      else $error("idle mode not left on activity");
   a_self_reset_pulse: assert property (@(posedge sys_clk) disable iff (reset)
      self_reset |=> !self_reset && mode_q == CMSS_NORMAL)
      else $error("self reset not one cycle");
   a_link_uninit: assert property (@(posedge sys_clk) disable iff (reset)
      !initialized |=> !self_reset)
      else $error("self reset before initialisation");
   a_blink_hold: assert property (@(posedge sys_clk) disable iff (reset)
      (cyclic_active && !ms_tick) |=> $stable(blink_q))
      else $error("indicator blink moved between ticks");

   // Calibration loader gating and pin zero use
   a_cal_gate: assert property (@(posedge sys_clk) disable iff (reset)
      !cal_enabled |=> !cal_load_start)
      else $error("load started while disabled");
   a_cal_load: assert property (@(posedge sys_clk) disable iff (reset)
      (cal_enabled && cal_load_req && !self_reset) |=> cal_load_start)
      else $error("enabled load not started");
   a_wake_fault: assert property (@(posedge sys_clk) disable iff (reset)
      gpio0_is_fault |-> !wake_event)
      else $error("wake raised in fault chain use");
endmodule : cmss_spi_slave

//--- sim/cmss_spi_master.sv
`timescale 1ns/1ps
// Host side: drives select, clock and data, and collects the reply
module cmss_spi_master
   import cmss_pkg::*;
#(
   parameter int HALF = 25
) (
   input wire logic sys_clk,
   input wire logic so,
   output cmss_pkg::cmss_spi_in_t spi_in
);
   // Select idles high and the clock stands low between frames
   initial spi_in = 3'b100;

   // One frame; HALF of 25 cycles per phase keeps the clock at 4 Mbps
   task automatic xfer(input int nbits, input logic [39:0] tx, output logic [39:0] rx);
      rx = '0;
      @(posedge sys_clk) spi_in.chip_select_bar <= 1'b0;
      repeat (HALF) @(posedge sys_clk);
      for (int i = 0; i < nbits; i++) begin
         spi_in.si <= tx[39];
         tx = {tx[38:0], tx[39]};
         repeat (HALF) @(posedge sys_clk);
         rx = {rx[38:0], so};
         spi_in.sclk <= 1'b1;
         repeat (HALF) @(posedge sys_clk);
         spi_in.sclk <= 1'b0;
      end
      repeat (HALF) @(posedge sys_clk);
      spi_in.chip_select_bar <= 1'b1;
      // Released data line must not keep showing the last bit
      spi_in.si <= ~spi_in.si;
      repeat (3) @(posedge sys_clk);
   endtask : xfer
endmodule : cmss_spi_master

//--- sim/cmss_spi_slave_test.sv
`timescale 1ns/1ps
module cmss_spi_slave_test;
   import cmss_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [39:0] aw = '0;
   logic act = 1'b0, init = 1'b0, cyc = 1'b0, cal_set = 1'b0, cal_req = 1'b0;
   logic g_in = 1'b0, g_flt = 1'b0, clr = 1'b0, prev_ind = 1'b1, seen_good = 1'b0;
   logic [12:0] blink_ms = 13'd100;
   logic so, so_oe, rx_valid, cal_en, cal_go, wake, fchain, lflag, self_rst, ind;
   logic [7:0] lcount;
   cmss_frame_t rx_frame;
   cmss_spi_in_t spi_in;
   int err_count = 0, total_checks = 0, cycles = 0, toggles = 0, exp_err = 0, n;
   logic [39:0] got_q[$];
   int nb[7] = '{40, 40, 39, 41, 40, 0, 40};
   bit bc[7] = '{0, 0, 0, 0, 1, 0, 0};

   cmss_spi_slave #(.IDLE_CYCLES(200), .LINK_CYCLES(100), .MS_CYCLES(4)) uut (
      .sys_clk(sys_clk), .reset(reset), .spi_in(spi_in), .so(so), .so_oe(so_oe),
      .answer_word(aw), .rx_frame(rx_frame), .rx_valid(rx_valid),
      .daisy_chain_transport_act(act), .initialized(init), .cyclic_active(cyc),
      .blink_period_ms(blink_ms), .cal_enable_set(cal_set), .cal_enabled(cal_en),
      .cal_load_req(cal_req), .cal_load_start(cal_go), .gpio0_in(g_in),
      .gpio0_is_fault(g_flt), .wake_event(wake), .fault_chain_in(fchain),
      .link_error_clear(clr), .link_error_flag(lflag), .link_error_count(lcount),
      .normal_mode_indicator(ind), .self_reset(self_rst));

   cmss_spi_master u_master (.sys_clk(sys_clk), .so(so), .spi_in(spi_in));

   initial forever #2.5 sys_clk = ~sys_clk;

   // Collects delivered frames, counts blinks and cuts a hang short
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (rx_valid === 1'b1) got_q.push_back(rx_frame);
      if (spi_in.chip_select_bar === 1'b0) check(40'(so_oe), 40'h1);
      if (cyc && ind !== prev_ind) toggles <= toggles + 1;
      prev_ind <= ind;
      if (cycles == 40000) begin
         err_count++;
         conclude();
      end
   end

   // Reference check value, MSB first over the 32 payload bits
   function automatic logic [7:0] crc8(input logic [31:0] p);
      logic [7:0] c;
      c = 8'hff;
      for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ p[i]) ? 8'h2f : 8'h00);
      return c;
   endfunction : crc8

   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One frame against the reference: reply, delivery and fault count
   task automatic frame(input int nbits, input bit bad);
      logic [39:0] tx, rx, exp_rx;
      bit good;
      good = (nbits == 40) && !bad;
      tx[39:8] = $urandom();
      tx[7:0] = crc8(tx[39:8]) ^ {7'h0, bad};
      exp_rx = {$urandom(), 8'($urandom())};
      @(posedge sys_clk) aw <= exp_rx;
      if (!seen_good) exp_rx = '0;
      u_master.xfer(nbits, tx, rx);
      repeat (2) @(posedge sys_clk);
      #1;
      if (nbits == 40) check(rx, exp_rx);
      check(40'(got_q.size()), 40'(good));
      if (good) check(got_q.pop_front(), tx);
      if (nbits != 0 && !good) exp_err++;
      check(40'(lcount), 40'(exp_err));
      check(40'(lflag), 40'(exp_err > 0));
      check(40'(so_oe), 40'h0);
      seen_good |= good;
      got_q.delete();
   endtask : frame

   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude

   // Main sequence
   initial begin
      void'($urandom(32'he0c5f318));
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk) #1;
      check(40'(ind), 40'h1);
      check(40'(cal_en), 40'h0);
      @(posedge sys_clk) cyc <= 1'b1;
      for (int k = 0; k < 7; k++) frame(nb[k], bc[k]);
      check(40'(toggles >= 2), 40'h1);
      $display("frame tests done");
      @(posedge sys_clk) cyc <= 1'b0;
      clr <= 1'b1;
      @(posedge sys_clk) clr <= 1'b0;
      @(posedge sys_clk) #1;
      check(40'(lflag), 40'h0);
      n = 0;
      while (ind === 1'b1 && n < 400) begin
         @(posedge sys_clk) #1;
         n++;
      end
      check(40'(n >= 160 && n <= 201), 40'h1);
      // Both uses of pin zero; the plain one also wakes the device
      for (int f = 1; f >= 0; f--) begin
         @(posedge sys_clk) g_flt <= f[0];
         g_in <= 1'b0;
         @(posedge sys_clk) g_in <= 1'b1;
         #1;
         check(40'(wake), 40'(!f[0]));
         check(40'(fchain), 40'(f[0]));
      end
      repeat (3) @(posedge sys_clk);
      #1 check(40'(ind), 40'h1);
      // Load refused while disabled, accepted once enabled
      for (int e = 0; e < 2; e++) begin
         @(posedge sys_clk) cal_req <= 1'b1;
         @(posedge sys_clk) cal_req <= 1'b0;
         #1 check(40'(cal_go), 40'(e));
         @(posedge sys_clk) cal_set <= 1'b1;
         @(posedge sys_clk) cal_set <= 1'b0;
         #1 check(40'(cal_en), 40'h1);
      end
      $display("pin and calibration tests done");
      @(posedge sys_clk) init <= 1'b1;
      n = 0;
      while (self_rst !== 1'b1 && n < 300) begin
         @(posedge sys_clk) #1;
         n++;
      end
      check(40'(n >= 95 && n <= 105), 40'h1);
      check(40'(ind), 40'h0);
      @(posedge sys_clk) init <= 1'b0;
      #1 check(40'(cal_en), 40'h0);
      $display("timeout tests done");
      conclude();
   end
endmodule : cmss_spi_slave_test
